// ===== shared/pel_pkg.sv
// What this block does
// - programmer commands, executive only replies
// - one command outstanding, one response each
// - logic clocked from internal 8 MHz oscillator
// - commands via fast word, replies via data
// - read returns memory words after header
// - every command gets a status response
// - header is 16-bit opcode plus operand
// - operand always sent, ignored when unused
// - unknown opcode gets NACK, nothing executed
// - operand gives read length
// - decode opcodes zero through thirteen
// - read length below 65536 words
// - single-word write generates no ECC parity
// - response header is command and code
// - codes: 0 pass, 2 fail, 3 unknown
// - echoed field is the processed opcode
package pel_pkg;
    localparam int          RC_CLOCK_MHZ   = 8;      // nominal oscillator rate
    localparam logic [15:0] OP_ROW_WRITE   = 16'h0000;
    localparam logic [15:0] OP_READ        = 16'h0001;
    localparam logic [15:0] OP_MULTI_ROW   = 16'h0002;
    localparam logic [15:0] OP_WORD_WRITE  = 16'h0003;
    localparam logic [15:0] OP_CHIP_ERASE  = 16'h0004;
    localparam logic [15:0] OP_PAGE_ERASE  = 16'h0005;
    localparam logic [15:0] OP_BLANK_CHECK = 16'h0006;
    localparam logic [15:0] OP_VERSION     = 16'h0007;
    localparam logic [15:0] OP_CRC         = 16'h0008;
    localparam logic [15:0] OP_CLUSTER     = 16'h0009;
    localparam logic [15:0] OP_HW_ID       = 16'h000a;
    localparam logic [15:0] OP_CFG_CHANGE  = 16'h000b;
    localparam logic [15:0] OP_CHECKSUM    = 16'h000c;
    localparam logic [15:0] OP_FOUR_WORD   = 16'h000d;
    localparam logic [15:0] OP_LAST        = OP_FOUR_WORD;
    localparam logic [15:0] RSP_PASS       = 16'h0000;
    localparam logic [15:0] RSP_FAIL       = 16'h0002;
    localparam logic [15:0] RSP_NACK       = 16'h0003;
    localparam logic [31:0] ADDR_STEP      = 32'h0000_0004;
    localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
    localparam int          EXIT_HOLD_CYCLES = 16;   // quiet link cycles before clear

    typedef struct packed {
        logic [15:0] opcode;
        logic [15:0] operand;
    } pel_cmd_hdr_t;

    typedef struct packed {
        logic [15:0] last_cmd;
        logic [15:0] code;
    } pel_rsp_hdr_t;

    typedef struct packed {
        logic [15:0] opcode;
        logic [15:0] operand;
        logic        no_ecc;
    } pel_exec_req_t;
endpackage

// ===== core/pel_executive.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// three-stage level synchroniser plus an output flop; a change counts once stages two and three agree
module pel_sync3
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic d,
    output logic      q
);
    logic s1_r, s2_r, s3_r;
    // first stage feeds the second stage only
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            {s1_r, s2_r, s3_r, q} <= 4'h0;
        end
        else
        begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                q <= s3_r;
        end
    end
endmodule
////////////////////////////////////////////////////////////////////////////////
module pel_executive
    import pel_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          link_clk,
    input  wire logic          link_rstn,
    input  wire logic          fast_word_valid,
    input  wire logic [31:0]   fast_word,
    output logic               fast_word_ready,
    output logic               processor_access_flag,
    output logic [31:0]        reply_word,
    input  wire logic          reply_resume,
    output logic               exec_req_valid,
    output pel_exec_req_t      exec_req,
    output logic               exec_word_valid,
    output logic [31:0]        exec_word,
    input  wire logic          exec_done,
    input  wire logic          exec_fail,
    input  wire logic          exec_result_valid,
    input  wire logic [31:0]   exec_result,
    output logic               mem_rd,
    output logic [31:0]        mem_addr,
    input  wire logic          mem_rvalid,
    input  wire logic [31:0]   mem_rdata
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_EXEC, ST_HDR, ST_WAIT, ST_RD_REQ, ST_RD_WAIT
    } pel_state_t;

    // link-domain state
    logic [31:0]  fw_hold_r;
    logic         fw_tog_r, rsp_ack_tog_r, fw_ack_q, fw_ack_prev_r, rsp_q, rsp_prev_r;
    // core-domain state
    pel_state_t   state_r;
    logic         fw_q, fw_prev_r, fw_pend_r, fw_ack_tog_r, ack_q, ack_prev_r, rsp_tog_r;
    logic [31:0]  rsp_word_r, addr_r, res_r;
    logic [15:0]  op_r, operand_r, code_r, left_r;
    logic [16:0]  sent_cnt_r;
    logic         res_pend_r, cmd_open_r, fw_take, ack_evt, fw_evt;
    pel_cmd_hdr_t hdr;
    ////////////////////////////////////////////////////////////////////////////
    // link side: one fast word held at a time, refused until the core acks it
    pel_sync3 u_fw_ack_sync (.clk(link_clk), .rstn(link_rstn), .d(fw_ack_tog_r), .q(fw_ack_q));
    pel_sync3 u_rsp_sync    (.clk(link_clk), .rstn(link_rstn), .d(rsp_tog_r),    .q(rsp_q));
    always_ff @(posedge link_clk)
    begin
        if (!link_rstn)
        begin
            fw_hold_r       <= RESET_WORD;
            {fw_tog_r, fw_ack_prev_r} <= 2'h0;
            fast_word_ready <= 1'b1;
        end
        else
        begin
            fw_ack_prev_r <= fw_ack_q;
            if (fast_word_valid && fast_word_ready)
            begin
                fw_hold_r       <= fast_word;        // commands enter only here
                fw_tog_r        <= ~fw_tog_r;
                fast_word_ready <= 1'b0;
            end
            else if (fw_ack_q != fw_ack_prev_r)
                fast_word_ready <= 1'b1;
        end
    end

    // reply word is captured whole and the access flag goes up on the same edge, staying up until resume
    always_ff @(posedge link_clk)
    begin
        if (!link_rstn)
        begin
            reply_word            <= RESET_WORD;
            {processor_access_flag, rsp_ack_tog_r, rsp_prev_r} <= 3'h0;
        end
        else
        begin
            rsp_prev_r <= rsp_q;
            if (rsp_q != rsp_prev_r)
            begin
                reply_word            <= rsp_word_r;  // stable: core waits for ack
                processor_access_flag <= 1'b1;
            end
            else if (reply_resume && processor_access_flag)
            begin
                processor_access_flag <= 1'b0;
                rsp_ack_tog_r         <= ~rsp_ack_tog_r;
            end
        end
    end

    AST_FLAG_HOLDS: assert property (@(posedge link_clk) disable iff (!link_rstn)
        processor_access_flag && !reply_resume |=> processor_access_flag && $stable(reply_word))
        else $error("reply word or access flag moved before resume");
    ////////////////////////////////////////////////////////////////////////////
    // core side crossings; this clock stands for the internal oscillator
    pel_sync3 u_fw_sync  (.clk(clk), .rstn(rstn), .d(fw_tog_r),      .q(fw_q));
    pel_sync3 u_ack_sync (.clk(clk), .rstn(rstn), .d(rsp_ack_tog_r), .q(ack_q));
    assign fw_evt  = fw_q != fw_prev_r;
    assign ack_evt = ack_q != ack_prev_r;
    assign hdr     = pel_cmd_hdr_t'(fw_hold_r);
    // words are taken only while a command is being gathered
    assign fw_take = fw_pend_r && (state_r == ST_IDLE || state_r == ST_ADDR
                                   || state_r == ST_EXEC);

    // pending word flag; the link cannot send again before the ack
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            {fw_prev_r, ack_prev_r, fw_pend_r, fw_ack_tog_r} <= 4'h0;
        end
        else
        begin
            fw_prev_r  <= fw_q;
            ack_prev_r <= ack_q;
            if (fw_evt)
                fw_pend_r <= 1'b1;
            else if (fw_take)
                fw_pend_r <= 1'b0;
            if (fw_take)
                fw_ack_tog_r <= ~fw_ack_tog_r;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // command interpreter
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_r         <= ST_IDLE;
            op_r            <= 16'h0000;
            operand_r       <= 16'h0000;
            code_r          <= RSP_PASS;
            addr_r          <= RESET_WORD;
            left_r          <= 16'h0000;
            res_pend_r      <= 1'b0;
            res_r           <= RESET_WORD;
            rsp_tog_r       <= 1'b0;
            rsp_word_r      <= RESET_WORD;
            exec_req_valid  <= 1'b0;
            exec_req        <= '0;
            exec_word_valid <= 1'b0;
            exec_word       <= RESET_WORD;
            mem_rd          <= 1'b0;
            mem_addr        <= RESET_WORD;
        end
        else
        begin
            exec_req_valid  <= 1'b0;
            exec_word_valid <= 1'b0;
            mem_rd          <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    if (fw_take)
                    begin
                        op_r      <= hdr.opcode;
                        operand_r <= hdr.operand;
                        if (hdr.opcode > OP_LAST)
                        begin
                            code_r  <= RSP_NACK;         // nothing executed
                            state_r <= ST_HDR;
                        end
                        else if (hdr.opcode == OP_READ)
                            state_r <= ST_ADDR;
                        else
                        begin
                            exec_req_valid  <= 1'b1;     // operand passed, used or not
                            exec_req.opcode  <= hdr.opcode;
                            exec_req.operand <= hdr.operand;
                            exec_req.no_ecc  <= hdr.opcode == OP_WORD_WRITE;
                            state_r <= ST_EXEC;
                        end
                    end
                end
                ST_ADDR:
                begin
                    if (fw_take)
                    begin
                        addr_r  <= fw_hold_r;
                        left_r  <= operand_r;            // length from operand
                        code_r  <= RSP_PASS;
                        state_r <= ST_HDR;
                    end
                end
                ST_EXEC:
                begin
                    if (fw_take)
                    begin
                        exec_word_valid <= 1'b1;
                        exec_word       <= fw_hold_r;
                    end
                    if (exec_done)
                    begin
                        code_r     <= exec_fail ? RSP_FAIL : RSP_PASS;
                        res_pend_r <= exec_result_valid;
                        res_r      <= exec_result;
                        state_r    <= ST_HDR;
                    end
                end
                ST_HDR:
                begin
                    rsp_word_r <= {op_r, code_r};        // echo processed opcode
                    rsp_tog_r  <= ~rsp_tog_r;
                    state_r    <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (ack_evt)
                    begin
                        if (res_pend_r)
                        begin
                            rsp_word_r <= res_r;
                            rsp_tog_r  <= ~rsp_tog_r;
                            res_pend_r <= 1'b0;
                        end
                        else if (op_r == OP_READ && left_r != 16'h0000)
                            state_r <= ST_RD_REQ;        // data words follow header
                        else
                            state_r <= ST_IDLE;          // next command only now
                    end
                end
                ST_RD_REQ:
                begin
                    mem_rd   <= 1'b1;
                    mem_addr <= addr_r;
                    state_r  <= ST_RD_WAIT;
                end
                ST_RD_WAIT:
                begin
                    if (mem_rvalid)
                    begin
                        rsp_word_r <= mem_rdata;         // whole 32-bit word in one reply
                        rsp_tog_r  <= ~rsp_tog_r;
                        addr_r     <= addr_r + ADDR_STEP;
                        left_r     <= left_r - 16'h0001;
                        state_r    <= ST_WAIT;
                    end
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // helper bookkeeping read only by the checks below
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sent_cnt_r <= 17'h00000;
            cmd_open_r <= 1'b0;
        end
        else
        begin
            if (state_r == ST_IDLE)
                sent_cnt_r <= 17'h00000;
            else if (state_r == ST_HDR || (state_r == ST_RD_WAIT && mem_rvalid))
                sent_cnt_r <= sent_cnt_r + 17'h00001;
            if (state_r == ST_IDLE && fw_take)
                cmd_open_r <= 1'b1;
            else if (state_r == ST_WAIT && ack_evt && !res_pend_r
                     && !(op_r == OP_READ && left_r != 16'h0000))
                cmd_open_r <= 1'b0;
        end
    end

    AST_NACK_UNKNOWN: assert property (@(posedge clk) disable iff (!rstn)
        state_r == ST_IDLE && fw_take && hdr.opcode > OP_LAST
        |=> code_r == RSP_NACK ##1 rsp_word_r == {op_r, RSP_NACK})
        else $error("unknown opcode not answered with NACK");
    AST_ECHO_HEADER: assert property (@(posedge clk) disable iff (!rstn)
        state_r == ST_HDR |=> rsp_word_r[31:16] == op_r && $changed(rsp_tog_r))
        else $error("response header does not echo the opcode");
    AST_ONE_OUTSTANDING: assert property (@(posedge clk) disable iff (!rstn)
        state_r inside {ST_HDR, ST_WAIT, ST_RD_REQ, ST_RD_WAIT} |=> $stable(fw_ack_tog_r))
        else $error("word taken while a response is open");
    AST_READ_COUNT: assert property (@(posedge clk) disable iff (!rstn)
        state_r == ST_WAIT && ack_evt && op_r == OP_READ && left_r == 16'h0000
        |-> sent_cnt_r == {1'b0, operand_r} + 17'h00001)
        else $error("read answered with wrong word count");
    AST_NO_ECC: assert property (@(posedge clk) disable iff (!rstn)
        exec_req_valid && exec_req.opcode == OP_WORD_WRITE |-> exec_req.no_ecc)
        else $error("single-word write requested parity");
    AST_REPLY_ONLY: assert property (@(posedge clk) disable iff (!rstn)
        $changed(rsp_tog_r) |-> $past(cmd_open_r))
        else $error("reply sent with no command open");
    AST_CODE_LEGAL: assert property (@(posedge clk) disable iff (!rstn)
        state_r == ST_HDR |-> code_r == RSP_PASS || code_r == RSP_FAIL || code_r == RSP_NACK)
        else $error("illegal response code");
    AST_EXEC_ANSWER: assert property (@(posedge clk) disable iff (!rstn)
        state_r == ST_EXEC && exec_done |=> state_r == ST_HDR
        && code_r == (($past(exec_fail)) ? RSP_FAIL : RSP_PASS))
        else $error("executed command not answered with its status");

    COV_NACK: cover property (@(posedge clk) disable iff (!rstn)
        state_r == ST_HDR && code_r == RSP_NACK);
    COV_READ: cover property (@(posedge clk) disable iff (!rstn)
        state_r == ST_RD_WAIT && mem_rvalid);
    COV_EXEC_RESULT: cover property (@(posedge clk) disable iff (!rstn)
        state_r == ST_EXEC && exec_done && exec_result_valid);
endmodule

`default_nettype wire

// ===== dv/pel_prog_model.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// programmer side of the debug link: pushes words, polls and collects replies
module pel_prog_model
(
    input  wire logic        link_clk,
    output logic             fast_word_valid,
    output logic [31:0]      fast_word,
    input  wire logic        fast_word_ready,
    input  wire logic        processor_access_flag,
    input  wire logic [31:0] reply_word,
    output logic             reply_resume
);
    // idle levels before the first exchange
    initial
    begin
        fast_word_valid = 1'b0;
        fast_word       = 32'h0;
        reply_resume    = 1'b0;
    end

    // offer one word and hold it until an edge samples ready high
    task automatic push_word(input logic [31:0] w, input int bound, output logic ok);
        ok = 1'b0;
        @(negedge link_clk);
        fast_word_valid = 1'b1;
        fast_word       = w;
        for (int i = 0; i < bound && !ok; i++)
        begin
            @(posedge link_clk);
            ok = (fast_word_ready === 1'b1);
        end
        @(negedge link_clk);
        fast_word_valid = 1'b0;
        fast_word       = ~w; // released data is scrambled so stale values never match
    endtask

    // poll the access flag, capture the word, then let the processor resume
    task automatic fetch_reply(input int bound, output logic [31:0] r, output logic ok);
        ok = 1'b0;
        r  = 32'h0;
        for (int i = 0; i < bound && !ok; i++)
        begin
            @(posedge link_clk);
            if (processor_access_flag === 1'b1)
            begin
                ok = 1'b1;
                r  = reply_word;
            end
        end
        if (ok)
        begin
            @(negedge link_clk);
            reply_resume = 1'b1;
            @(negedge link_clk);
            reply_resume = 1'b0;
            // wait for the flag to drop so a stale flag is never read twice
            for (int i = 0; i < 8 && processor_access_flag !== 1'b0; i++)
                @(posedge link_clk);
            ok = (processor_access_flag === 1'b0); // a flag that never drops is a failure
        end
    endtask

    // end of session: valid and resume low for the exit interval before the clear pin moves; fast_word keeps its last value
    task automatic end_session(input int hold);
        @(negedge link_clk);
        fast_word_valid = 1'b0;
        reply_resume    = 1'b0;
        repeat (hold) @(posedge link_clk);
    endtask
endmodule

`default_nettype wire

// ===== dv/prog_executive_cmd_link_test.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module prog_executive_cmd_link_test
    import pel_pkg::*;
;
    logic          clk = 1'b0;
    logic          link_clk = 1'b1;
    logic          rstn = 1'b0;
    logic          link_rstn = 1'b0;
    logic          fast_word_valid, fast_word_ready, processor_access_flag, reply_resume;
    logic [31:0]   fast_word, reply_word, exec_word, mem_addr;
    logic          exec_req_valid, exec_word_valid, mem_rd;
    pel_exec_req_t exec_req, last_req;
    logic          exec_done = 1'b0, exec_fail = 1'b0, exec_result_valid = 1'b0;
    logic [31:0]   exec_result = 32'h0, mem_rdata = 32'h0, last_word;
    logic          mem_rvalid = 1'b0;
    logic [31:0]   rd_q[$];
    int            miscompares = 0, compares = 0, req_cnt = 0, word_cnt = 0;
    int unsigned   seed_dummy;

    always #2 clk = ~clk;
    always #6 link_clk = ~link_clk; // 12 ns link, three core periods, fixed phase to the core

    pel_executive uut (.clk(clk), .rstn(rstn), .link_clk(link_clk), .link_rstn(link_rstn),
        .fast_word_valid(fast_word_valid), .fast_word(fast_word),
        .fast_word_ready(fast_word_ready), .processor_access_flag(processor_access_flag),
        .reply_word(reply_word), .reply_resume(reply_resume),
        .exec_req_valid(exec_req_valid), .exec_req(exec_req),
        .exec_word_valid(exec_word_valid), .exec_word(exec_word), .exec_done(exec_done),
        .exec_fail(exec_fail), .exec_result_valid(exec_result_valid),
        .exec_result(exec_result), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

    pel_prog_model prog (.link_clk(link_clk), .fast_word_valid(fast_word_valid),
        .fast_word(fast_word), .fast_word_ready(fast_word_ready),
        .processor_access_flag(processor_access_flag), .reply_word(reply_word),
        .reply_resume(reply_resume));

    ////////////////////////////////////////////////////////////////////////////////
    // memory contents derived from the address, so a wrong step shows as wrong data
    function automatic logic [31:0] mem_fn(input logic [31:0] a);
        return {a[15:0], ~a[31:16]};
    endfunction

    // watch the executor and memory request ports
    always @(posedge clk)
    begin
        if (exec_req_valid === 1'b1)
        begin
            req_cnt++;
            last_req = exec_req;
        end
        if (exec_word_valid === 1'b1)
        begin
            word_cnt++;
            last_word = exec_word;
        end
        if (mem_rd === 1'b1)
            rd_q.push_back(mem_addr);
    end

    // memory answers after a random latency of one to three cycles
    initial
    forever
    begin
        @(negedge clk);
        mem_rvalid = 1'b0;
        mem_rdata  = ~mem_rdata;
        if (rd_q.size() != 0)
        begin
            repeat ($urandom_range(2)) @(negedge clk);
            mem_rdata  = mem_fn(rd_q.pop_front());
            mem_rvalid = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic push(input logic [31:0] w);
        logic ok;
        prog.push_word(w, 64, ok);
        if (!ok)
        begin
            miscompares++;
            report_and_stop();
        end
    endtask

    task automatic fetch(output logic [31:0] r);
        logic ok;
        prog.fetch_reply(200, r, ok);
        if (!ok)
        begin
            miscompares++;
            report_and_stop();
        end
    endtask

    // after a complete response nothing more may be offered
    task automatic quiet();
        logic [31:0] r;
        logic        ok;
        prog.fetch_reply(30, r, ok);
        check(ok, 1'b0);
    endtask

    task automatic run_exec(input logic [15:0] op, input logic fail, input logic res_v);
        logic [31:0] r, pay, res, hdr;
        int          n0, w0;
        pay = $urandom;
        res = $urandom;
        hdr = {op, 16'($urandom)};
        n0  = req_cnt;
        w0  = word_cnt;
        push(hdr);
        push(pay);
        for (int i = 0; i < 200 && word_cnt == w0; i++)
            @(posedge clk);
        if (word_cnt == w0)
        begin
            miscompares++;
            report_and_stop();
        end
        check(req_cnt - n0, 1);
        check(last_req.opcode, op);
        check(last_req.operand, hdr[15:0]);
        check(last_req.no_ecc, op == OP_WORD_WRITE);
        check(last_word, pay);
        @(negedge clk);
        exec_done         = 1'b1;
        exec_fail         = fail;
        exec_result_valid = res_v;
        exec_result       = res;
        @(negedge clk);
        exec_done         = 1'b0;
        exec_fail         = 1'b0;
        exec_result_valid = 1'b0;
        exec_result       = ~res;
        fetch(r);
        check(r, {op, fail ? RSP_FAIL : RSP_PASS});
        if (res_v)
        begin
            fetch(r);
            check(r, res);
        end
        quiet();
    endtask

    task automatic run_read(input logic [15:0] n);
        logic [31:0] r, a;
        a = $urandom;
        push({OP_READ, n});
        push(a);
        fetch(r);
        check(r, {OP_READ, RSP_PASS});
        for (int i = 0; i < n; i++)
        begin
            fetch(r);
            check(r, mem_fn(a + ADDR_STEP * i));
        end
        quiet();
    endtask

    task automatic run_nack(input logic [15:0] op);
        logic [31:0] r;
        int          n0;
        n0 = req_cnt;
        push({op, 16'($urandom)});
        fetch(r);
        check(r, {op, RSP_NACK});
        check(req_cnt - n0, 0);
        quiet();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence: reset, idle check, every opcode, unknown codes, reads
    initial
    begin
        seed_dummy = $urandom(82);
        repeat (5) @(negedge link_clk);
        @(negedge clk); // keep the release off the core's sampling edge
        rstn      = 1'b1;
        link_rstn = 1'b1;
        check(fast_word_ready, 1'b1);
        quiet();
        for (logic [15:0] op = 16'h0000; op <= OP_LAST; op++)
            if (op != OP_READ)
                run_exec(op, 1'($urandom_range(1)), 1'($urandom_range(1)));
        run_exec(OP_WORD_WRITE, 1'b1, 1'b1);
        run_exec(OP_FOUR_WORD, 1'b0, 1'b0);
        run_nack(16'h000e);
        run_nack(16'hffff);
        repeat (3) run_nack(16'($urandom_range(16'hffff, 16'h000e)));
        run_read(16'h0000);
        run_read(16'h0001);
        repeat (2) run_read(16'($urandom_range(6, 2)));
        // leave programming mode and come back: quiet lines, clear pin, extra clocks
        prog.end_session(EXIT_HOLD_CYCLES);
        @(negedge clk);
        rstn      = 1'b0; // mode sequence has no pin here; the clear pin follows
        link_rstn = 1'b0;
        repeat (3) @(posedge link_clk); // programming clock keeps pulsing in clear
        @(negedge clk);
        rstn      = 1'b1;
        link_rstn = 1'b1;
        check(fast_word_ready, 1'b1);
        check(processor_access_flag, 1'b0);
        run_nack(16'($urandom_range(16'hffff, 16'h000e)));
        run_read(16'h0002);
        report_and_stop();
    end
endmodule

`default_nettype wire
